// ---- cscp_map.vh ----
`ifndef CSCP_MAP_VH
`define CSCP_MAP_VH
// Bytes of the serial protocol
`define CSCP_CR          8'h0d
`define CSCP_EOT         8'h04
`define CSCP_START       8'h3e
// Line limits
`define CSCP_MAX_DIGITS  7
`define CSCP_LINE_MAX    4'h8
// Serial framing and timing
`define CSCP_CLK_HZ      50000000
`define CSCP_BAUD        9600
`define CSCP_BAUD_DIV    (`CSCP_CLK_HZ / `CSCP_BAUD)
// Result codes
`define CSCP_RES_OK      3'h0
`define CSCP_RES_CMD     3'h1
`define CSCP_RES_OVR     3'h2
`define CSCP_RES_VAL     3'h3
`define CSCP_RES_MEM     3'h4
// Memory operations
`define CSCP_MOP_SAVE    2'h0
`define CSCP_MOP_LOAD    2'h1
`define CSCP_MOP_INIT    2'h2
`define CSCP_MOP_CORR    2'h3
// Settings vector layout (position)
`define CSCP_CFG_W       106
`define CSCP_F_MODE      0
`define CSCP_F_PERIOD    2
`define CSCP_F_GAIN_AO   22
`define CSCP_F_GAIN_AE   31
`define CSCP_F_GAIN_BO   40
`define CSCP_F_GAIN_BE   49
`define CSCP_F_OFF_AO    58
`define CSCP_F_OFF_AE    62
`define CSCP_F_OFF_BO    66
`define CSCP_F_OFF_BE    70
`define CSCP_F_VIDEO     74
`define CSCP_F_CORR      77
`define CSCP_F_TARGET    79
`define CSCP_F_DL_EN     87
`define CSCP_F_DL_MIN    88
`define CSCP_F_DL_MAX    96
`define CSCP_F_DIR       104
`define CSCP_F_TEST      105
// Factory defaults
`define CSCP_DEF_PERIOD  20'd4000
`define CSCP_DEF_OFFSET  4'h1
`define CSCP_DEF_CORR    2'h1
`define CSCP_DEF_TARGET  8'h80
`define CSCP_DEF_DL_MAX  8'hff
// Value limits
`define CSCP_PERIOD_MIN  24'd4000
`define CSCP_PERIOD_MAX  24'd1048575
`define CSCP_GAIN_MAX    24'd350
`define CSCP_OFF_MAX     24'd15
`define CSCP_DL_MIN_MAX  24'd128
`define CSCP_DL_MAX_MIN  24'd129
`define CSCP_BYTE_MAX    24'd255
// APB map
`define CSCP_A_CTRL      12'h000
`define CSCP_A_STATUS    12'h004
`define CSCP_A_CFG0      12'h010
`define CSCP_A_CFG1      12'h014
`define CSCP_A_CFG2      12'h018
`define CSCP_A_CFG3      12'h01c
`define CSCP_CTRL_RST    32'h00000001
`endif

// ---- cscp_parser.v ----
// Functional notes
// - Each command ends in CR 0x0d; letter alone or letter plus value.
// - Command byte is one letter; a digit there is invalid.
// - Value is up to seven ASCII decimal digits, accumulated to binary.
// - Reply: start char, result, CR, start char, echo, CR; success says OK.
// - Every reply ends in one EOT byte 0x04 after the last CR.
// - Load reply has three lines: OK, memory readout, echoed command.
// - Unknown letter answers CMD ERR!; memory failure answers MEM ERR!.
// - Line too long before CR is rejected with CMD OVR ERR!.
// - Out of range value keeps the setting and answers VAL ERR!.
// - Command t picks exposure mode 0 to 3.
// - Command i sets scan period, 4000 to 1048575 cycles.
// - Gains g G b B take 0 to 350, meaning one to six times.
// - Offsets o O p P take 0 to 15.
// - Command C picks correction off, factory white or user data.
// - Command M sets correction target level 0 to 255.
// - W and K capture user white and black data; L saves it.
// - c enables level adjust; s min 0 to 128; S max 129 to 255.
// - T selects image data or test pattern.
// - w saves settings, I loads and applies them, z restores defaults.
// - CC1 is the trigger, used only in trigger modes; CC2 to CC4 unused.
// - Commands come in on the command pair, replies leave on the reply pair.
// - Command v accepts only 0, 1 and 6.
// - Command R takes 0 forward or 1 reverse.
// - Tap one pixels 1 to 3700, tap two 3701 to 7400 descending.
//
// Our own choices: the register offsets and the APB register port.
`include "cscp_map.vh"
`timescale 1ns/100ps
`default_nettype none
module cscp_parser #(
    parameter BAUD_DIV = `CSCP_BAUD_DIV
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output wire         pready,
    output reg          pslverr,
    input  wire         ser_cmd_in,
    output reg          ser_reply_out,
    input  wire         cc1_trig,
    output reg          trig_out,
    output reg          mem_req,
    output reg  [1:0]   mem_op,
    output wire [105:0] mem_wcfg,
    input  wire [105:0] mem_rcfg,
    input  wire         mem_done,
    input  wire         mem_err,
    output reg          cap_white,
    output reg          cap_black,
    output wire [1:0]   exp_mode,
    output wire [19:0]  scan_period,
    output wire [8:0]   gain_a_odd,
    output wire [8:0]   gain_a_even,
    output wire [8:0]   gain_b_odd,
    output wire [8:0]   gain_b_even,
    output wire [3:0]   offset_a_odd,
    output wire [3:0]   offset_a_even,
    output wire [3:0]   offset_b_odd,
    output wire [3:0]   offset_b_even,
    output wire [2:0]   video_fmt,
    output wire [1:0]   corr_sel,
    output wire [7:0]   corr_target,
    output wire         dl_enable,
    output wire [7:0]   dl_min,
    output wire [7:0]   dl_max,
    output wire         dir_reverse,
    output wire         test_pattern
);
    localparam [2:0] S_RX  = 3'b001;
    localparam [2:0] S_MEM = 3'b010;
    localparam [2:0] S_TX  = 3'b100;
    localparam [12:0] DIV  = BAUD_DIV[12:0];
    localparam [12:0] HALF = DIV >> 1;

    function [`CSCP_CFG_W-1:0] cfg_default;
        input dummy;
        begin
            cfg_default = {`CSCP_CFG_W{1'b0}};
            cfg_default[`CSCP_F_PERIOD +: 20] = `CSCP_DEF_PERIOD;
            cfg_default[`CSCP_F_OFF_AO +: 4]  = `CSCP_DEF_OFFSET;
            cfg_default[`CSCP_F_OFF_AE +: 4]  = `CSCP_DEF_OFFSET;
            cfg_default[`CSCP_F_OFF_BO +: 4]  = `CSCP_DEF_OFFSET;
            cfg_default[`CSCP_F_OFF_BE +: 4]  = `CSCP_DEF_OFFSET;
            cfg_default[`CSCP_F_CORR +: 2]    = `CSCP_DEF_CORR;
            cfg_default[`CSCP_F_TARGET +: 8]  = `CSCP_DEF_TARGET;
            cfg_default[`CSCP_F_DL_MAX +: 8]  = `CSCP_DEF_DL_MAX;
        end
    endfunction

    // 0 unknown, 1 needs a value, 2 valueless
    function [1:0] cmd_kind;
        input [7:0] c;
        begin
            case (c)
                "t", "i", "g", "G", "b", "B", "o", "O", "p", "P",
                "v", "C", "M", "c", "s", "S", "R", "T": cmd_kind = 2'h1;
                "W", "K", "L", "w", "I", "z": cmd_kind = 2'h2;
                default: cmd_kind = 2'h0;
            endcase
        end
    endfunction

    function val_ok;
        input [7:0]  c;
        input [23:0] v;
        begin
            case (c)
                "t": val_ok = (v <= 24'd3);
                "i": val_ok = (v >= `CSCP_PERIOD_MIN) && (v <= `CSCP_PERIOD_MAX);
                "g", "G", "b", "B": val_ok = (v <= `CSCP_GAIN_MAX);
                "o", "O", "p", "P": val_ok = (v <= `CSCP_OFF_MAX);
                "v": val_ok = (v == 24'd0) || (v == 24'd1) || (v == 24'd6);
                "C": val_ok = (v <= 24'd2);
                "M": val_ok = (v <= `CSCP_BYTE_MAX);
                "s": val_ok = (v <= `CSCP_DL_MIN_MAX);
                "S": val_ok = (v >= `CSCP_DL_MAX_MIN) && (v <= `CSCP_BYTE_MAX);
                "c", "R", "T": val_ok = (v <= 24'd1);
                default: val_ok = 1'b0;
            endcase
        end
    endfunction

    function [`CSCP_CFG_W-1:0] cfg_apply;
        input [`CSCP_CFG_W-1:0] f;
        input [7:0]  c;
        input [23:0] v;
        begin
            cfg_apply = f;
            case (c)
                "t": cfg_apply[`CSCP_F_MODE +: 2]     = v[1:0];
                "i": cfg_apply[`CSCP_F_PERIOD +: 20]  = v[19:0];
                "g": cfg_apply[`CSCP_F_GAIN_AO +: 9]  = v[8:0];
                "G": cfg_apply[`CSCP_F_GAIN_AE +: 9]  = v[8:0];
                "b": cfg_apply[`CSCP_F_GAIN_BO +: 9]  = v[8:0];
                "B": cfg_apply[`CSCP_F_GAIN_BE +: 9]  = v[8:0];
                "o": cfg_apply[`CSCP_F_OFF_AO +: 4]   = v[3:0];
                "O": cfg_apply[`CSCP_F_OFF_AE +: 4]   = v[3:0];
                "p": cfg_apply[`CSCP_F_OFF_BO +: 4]   = v[3:0];
                "P": cfg_apply[`CSCP_F_OFF_BE +: 4]   = v[3:0];
                "v": cfg_apply[`CSCP_F_VIDEO +: 3]    = v[2:0];
                "C": cfg_apply[`CSCP_F_CORR +: 2]     = v[1:0];
                "M": cfg_apply[`CSCP_F_TARGET +: 8]   = v[7:0];
                "c": cfg_apply[`CSCP_F_DL_EN]         = v[0];
                "s": cfg_apply[`CSCP_F_DL_MIN +: 8]   = v[7:0];
                "S": cfg_apply[`CSCP_F_DL_MAX +: 8]   = v[7:0];
                "R": cfg_apply[`CSCP_F_DIR]           = v[0];
                "T": cfg_apply[`CSCP_F_TEST]          = v[0];
                default: cfg_apply = f;
            endcase
        end
    endfunction

    reg [`CSCP_CFG_W-1:0] cfg_r;
    reg [2:0]  state_r;
    reg [7:0]  line_r [0:7];
    reg [3:0]  len_r;
    reg        ovr_r;
    reg        bad_r;
    reg [23:0] val_r;
    reg [2:0]  res_r;
    reg        load_ok_r;
    reg [31:0] ctrl_r;
    // Receiver
    reg        rx_busy_r;
    reg [12:0] rx_cnt_r;
    reg [3:0]  rx_bit_r;
    reg [7:0]  rx_sh_r;
    reg        rx_vld_r;
    // Transmitter and reply sequencer
    reg        tx_busy_r;
    reg [12:0] tx_cnt_r;
    reg [3:0]  tx_bit_r;
    reg [9:0]  tx_sh_r;
    reg [1:0]  seg_r;
    reg [4:0]  idx_r;
    reg [7:0]  tx_byte;
    reg        seg_last;
    reg [95:0] txt;
    reg [3:0]  txt_len;
    reg [3:0]  nib;
    integer    k;

    wire [7:0] cmd_byte = line_r[0];
    wire [7:0] rx_digit = rx_sh_r - "0";
    wire       rx_is_dig = (rx_sh_r >= "0") && (rx_sh_r <= "9");
    wire [107:0] cfg_hex = {2'b00, cfg_r};

    assign exp_mode      = cfg_r[`CSCP_F_MODE +: 2];
    assign scan_period   = cfg_r[`CSCP_F_PERIOD +: 20];
    assign gain_a_odd    = cfg_r[`CSCP_F_GAIN_AO +: 9];
    assign gain_a_even   = cfg_r[`CSCP_F_GAIN_AE +: 9];
    assign gain_b_odd    = cfg_r[`CSCP_F_GAIN_BO +: 9];
    assign gain_b_even   = cfg_r[`CSCP_F_GAIN_BE +: 9];
    assign offset_a_odd  = cfg_r[`CSCP_F_OFF_AO +: 4];
    assign offset_a_even = cfg_r[`CSCP_F_OFF_AE +: 4];
    assign offset_b_odd  = cfg_r[`CSCP_F_OFF_BO +: 4];
    assign offset_b_even = cfg_r[`CSCP_F_OFF_BE +: 4];
    assign video_fmt     = cfg_r[`CSCP_F_VIDEO +: 3];
    assign corr_sel      = cfg_r[`CSCP_F_CORR +: 2];
    assign corr_target   = cfg_r[`CSCP_F_TARGET +: 8];
    assign dl_enable     = cfg_r[`CSCP_F_DL_EN];
    assign dl_min        = cfg_r[`CSCP_F_DL_MIN +: 8];
    assign dl_max        = cfg_r[`CSCP_F_DL_MAX +: 8];
    assign dir_reverse   = cfg_r[`CSCP_F_DIR];
    assign test_pattern  = cfg_r[`CSCP_F_TEST];
    assign mem_wcfg      = cfg_r;
    assign pready        = 1'b1;

    // Byte receiver, mid-bit sampling, 8N1
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r  <= 13'h0000;
            rx_bit_r  <= 4'h0;
            rx_sh_r   <= 8'h00;
            rx_vld_r  <= 1'b0;
        end else begin
            rx_vld_r <= 1'b0;
            if (!rx_busy_r) begin
                if (!ser_cmd_in) begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= HALF;
                    rx_bit_r  <= 4'h0;
                end
            end else if (rx_cnt_r != 13'h0000) begin
                rx_cnt_r <= rx_cnt_r - 13'h0001;
            end else begin
                rx_cnt_r <= DIV - 13'h0001;
                if (rx_bit_r == 4'h0) begin
                    rx_busy_r <= ~ser_cmd_in;
                    rx_bit_r  <= 4'h1;
                end else if (rx_bit_r <= 4'h8) begin
                    rx_sh_r  <= {ser_cmd_in, rx_sh_r[7:1]};
                    rx_bit_r <= rx_bit_r + 4'h1;
                end else begin
                    rx_busy_r <= 1'b0;
                    rx_vld_r  <= ser_cmd_in; // Framing errors are dropped
                end
            end
        end
    end

    // Reply byte for the current segment and index
    always @* begin
        k = 0;
        nib = 4'h0;
        case (res_r)
            `CSCP_RES_OK:  begin txt = {80'h0, "OK"};        txt_len = 4'd2;  end
            `CSCP_RES_CMD: begin txt = {32'h0, "CMD ERR!"};  txt_len = 4'd8;  end
            `CSCP_RES_OVR: begin txt = "CMD OVR ERR!";       txt_len = 4'd12; end
            `CSCP_RES_VAL: begin txt = {32'h0, "VAL ERR!"};  txt_len = 4'd8;  end
            default:       begin txt = {32'h0, "MEM ERR!"};  txt_len = 4'd8;  end
        endcase
        tx_byte  = `CSCP_CR;
        seg_last = 1'b0;
        case (seg_r)
            2'h0: begin
                seg_last = (idx_r == {1'b0, txt_len} + 5'd1);
                if (idx_r == 5'd0)
                    tx_byte = `CSCP_START;
                else if (!seg_last) begin
                    k = txt_len - idx_r;
                    tx_byte = txt[8*k +: 8];
                end
            end
            2'h1: begin
                seg_last = (idx_r == 5'd28);
                if (idx_r == 5'd0)
                    tx_byte = `CSCP_START;
                else if (!seg_last) begin
                    k = 27 - idx_r;
                    nib = cfg_hex[4*k +: 4];
                    tx_byte = (nib < 4'ha) ? ("0" + nib) : ("a" + nib - 4'ha);
                end
            end
            2'h2: begin
                seg_last = (idx_r == {1'b0, len_r} + 5'd1);
                if (idx_r == 5'd0)
                    tx_byte = `CSCP_START;
                else if (!seg_last)
                    tx_byte = line_r[idx_r[2:0] - 3'h1];
            end
            default: begin
                seg_last = 1'b1;
                tx_byte  = `CSCP_EOT;
            end
        endcase
    end

    // Line parser, executor and reply transmitter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= S_RX;
            cfg_r     <= cfg_default(1'b0);
            len_r     <= 4'h0;
            ovr_r     <= 1'b0;
            bad_r     <= 1'b0;
            val_r     <= 24'h000000;
            res_r     <= `CSCP_RES_OK;
            load_ok_r <= 1'b0;
            mem_req   <= 1'b0;
            mem_op    <= `CSCP_MOP_SAVE;
            cap_white <= 1'b0;
            cap_black <= 1'b0;
            tx_busy_r <= 1'b0;
            tx_cnt_r  <= 13'h0000;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= 10'h3ff;
            ser_reply_out <= 1'b1;
            seg_r     <= 2'h0;
            idx_r     <= 5'd0;
        end else begin
            cap_white <= 1'b0;
            cap_black <= 1'b0;
            case (state_r)
                S_RX: begin
                    // Bytes during a reply are ignored; host must wait for EOT
                    if (rx_vld_r && ctrl_r[0]) begin
                        if (rx_sh_r == `CSCP_CR) begin
                            load_ok_r <= 1'b0;
                            seg_r     <= 2'h0;
                            idx_r     <= 5'd0;
                            state_r   <= S_TX;
                            if (ovr_r)
                                res_r <= `CSCP_RES_OVR;
                            else if (len_r == 4'h0 || bad_r || cmd_kind(cmd_byte) == 2'h0)
                                res_r <= `CSCP_RES_CMD;
                            else if (cmd_kind(cmd_byte) == 2'h1) begin
                                if (len_r > 4'h1 && val_ok(cmd_byte, val_r)) begin
                                    res_r <= `CSCP_RES_OK;
                                    cfg_r <= cfg_apply(cfg_r, cmd_byte, val_r);
                                end else
                                    res_r <= `CSCP_RES_VAL;
                            end else if (len_r > 4'h1)
                                res_r <= `CSCP_RES_VAL;
                            else begin
                                res_r <= `CSCP_RES_OK;
                                case (cmd_byte)
                                    "W": cap_white <= 1'b1;
                                    "K": cap_black <= 1'b1;
                                    default: begin
                                        state_r <= S_MEM;
                                        mem_req <= 1'b1;
                                        if (cmd_byte == "z")
                                            cfg_r <= cfg_default(1'b0);
                                        mem_op <= (cmd_byte == "w") ? `CSCP_MOP_SAVE :
                                                  (cmd_byte == "I") ? `CSCP_MOP_LOAD :
                                                  (cmd_byte == "z") ? `CSCP_MOP_INIT :
                                                  `CSCP_MOP_CORR;
                                    end
                                endcase
                            end
                        end else if (len_r == `CSCP_LINE_MAX) begin
                            ovr_r <= 1'b1;
                        end else begin
                            line_r[len_r[2:0]] <= rx_sh_r;
                            len_r <= len_r + 4'h1;
                            if (len_r == 4'h0)
                                bad_r <= rx_is_dig;
                            else if (!rx_is_dig)
                                bad_r <= 1'b1;
                            val_r <= (len_r == 4'h0) ? 24'h000000 :
                                     val_r * 24'd10 + {16'h0000, rx_digit};
                        end
                    end
                end
                S_MEM: begin
                    if (mem_done) begin
                        mem_req <= 1'b0;
                        state_r <= S_TX;
                        if (mem_err)
                            res_r <= `CSCP_RES_MEM;
                        else if (mem_op == `CSCP_MOP_LOAD) begin
                            cfg_r     <= mem_rcfg;
                            load_ok_r <= 1'b1;
                        end
                    end
                end
                S_TX: begin
                    if (tx_busy_r) begin
                        if (tx_cnt_r != 13'h0000)
                            tx_cnt_r <= tx_cnt_r - 13'h0001;
                        else begin
                            tx_cnt_r      <= DIV - 13'h0001;
                            ser_reply_out <= tx_sh_r[0];
                            tx_sh_r       <= {1'b1, tx_sh_r[9:1]};
                            tx_bit_r      <= tx_bit_r + 4'h1;
                            if (tx_bit_r == 4'ha) begin
                                tx_busy_r <= 1'b0;
                                // Wrapped to segment 0 only once EOT has gone out
                                if (seg_r == 2'h0 && idx_r == 5'd0) begin
                                    state_r <= S_RX;
                                    len_r   <= 4'h0;
                                    ovr_r   <= 1'b0;
                                    bad_r   <= 1'b0;
                                end
                            end
                        end
                    end else begin
                        tx_busy_r <= 1'b1;
                        tx_cnt_r  <= 13'h0000;
                        tx_bit_r  <= 4'h0;
                        tx_sh_r   <= {1'b1, tx_byte, 1'b0};
                        if (!seg_last)
                            idx_r <= idx_r + 5'd1;
                        else begin
                            idx_r <= 5'd0;
                            seg_r <= (seg_r == 2'h0 && !load_ok_r) ? 2'h2 : seg_r + 2'h1;
                        end
                    end
                end
                default: state_r <= S_RX;
            endcase
        end
    end

    // Trigger passes only in the external trigger modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trig_out <= 1'b0;
        else
            trig_out <= cc1_trig & (exp_mode != 2'h0);
    end

    // APB slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= `CSCP_CTRL_RST;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            if (psel && !penable) begin
                pslverr <= 1'b0;
                case (paddr)
                    `CSCP_A_CTRL:   prdata <= ctrl_r;
                    `CSCP_A_STATUS: prdata <= {28'h0000000, state_r != S_RX, res_r};
                    `CSCP_A_CFG0:   prdata <= cfg_r[31:0];
                    `CSCP_A_CFG1:   prdata <= cfg_r[63:32];
                    `CSCP_A_CFG2:   prdata <= cfg_r[95:64];
                    `CSCP_A_CFG3:   prdata <= {22'h0, cfg_r[105:96]};
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (psel && penable && pwrite && paddr == `CSCP_A_CTRL)
                ctrl_r <= {31'h0, pwdata[0]};
        end
    end
endmodule // cscp_parser
`default_nettype wire

// ---- cscp_parser_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module cscp_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ser_reply_out,
    input wire logic        cc1_trig,
    input wire logic        trig_out,
    input wire logic        mem_req,
    input wire logic        mem_done,
    input wire logic        cap_white,
    input wire logic        cap_black,
    input wire logic [1:0]  exp_mode,
    input wire logic [19:0] scan_period,
    input wire logic [8:0]  gain_a_odd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_TRIG_GATE: assert property (exp_mode == 0 && $past(exp_mode) == 0 |-> !trig_out)
        else $error("trigger passed in free run");
    AST_TRIG_FOLLOW: assert property (exp_mode != 0 && $past(exp_mode) != 0 |->
        trig_out == $past(cc1_trig)) else $error("trigger not forwarded");
    AST_CAP_PULSE: assert property ($rose(cap_white) |=> !cap_white)
        else $error("white capture pulse too long");
    AST_CAP_EXCL: assert property (!(cap_white && cap_black))
        else $error("both captures at once");
    AST_PERIOD_RANGE: assert property (scan_period >= 20'd4000)
        else $error("scan period below minimum");
    AST_GAIN_RANGE: assert property (gain_a_odd <= 9'd350)
        else $error("gain above maximum");
    AST_MEM_HOLD: assert property (mem_req && !mem_done |=> mem_req)
        else $error("memory request dropped early");
    AST_MEM_END: assert property (mem_req && mem_done |=> !mem_req)
        else $error("memory request not released");
    AST_QUIET_MEM: assert property (mem_req |-> ser_reply_out[*2])
        else $error("reply started before memory finished");
endmodule // cscp_checker
bind cscp_parser cscp_checker cscp_checker_i (.*);
`default_nettype wire

// ---- cscp_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cscp_host_model #(parameter int BAUD_DIV = 8) (
    input wire logic clk,
    output logic     tx,
    input wire logic rx
);
    string      rs;
    logic [7:0] b;
    initial tx = 1'b1;
    task automatic put_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx <= f[i];
            repeat (BAUD_DIV) @(posedge clk);
        end
    endtask
    task automatic send(input string c, output bit to);
        rs = "";
        for (int i = 0; i <= c.len(); i++) put_byte(i < c.len() ? c[i] : 8'h0d);
        to = 1;
        for (int n = 0; n < 8000 && to; n++) begin
            @(posedge clk);
            if (rs.len() > 0 && rs[rs.len()-1] == 8'h04) to = 0;
        end
        // Let the final stop bit end before the next line starts
        repeat (BAUD_DIV) @(posedge clk);
    endtask
    always begin
        @(negedge rx);
        repeat (BAUD_DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge clk);
            b[i] = rx;
        end
        repeat (BAUD_DIV) @(posedge clk);
        rs = {rs, string'(b)};
    end
endmodule // cscp_host_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {string c; string r;} cscp_row_t;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cc1_trig = 0;
    logic         mem_done = 0, mem_err = 0, mem_req, ser_cmd_in, ser_reply_out, pslverr, e;
    logic         pready, cap_white, cap_black, trig_out;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, rd;
    logic [105:0] mem_rcfg = 106'h3e82;
    logic [1:0]   exp_mode;
    logic [19:0]  scan_period;
    logic [8:0]   gain_a_odd;
    int           n_mismatch = 0, n_tests = 0;
    bit           to;
    cscp_row_t rows[] = '{'{"t3","OK"}, '{"t4","VAL ERR!"}, '{"i4000","OK"}, '{"i3999","VAL ERR!"},
        '{"i1048575","OK"}, '{"i1048576","VAL ERR!"}, '{"g350","OK"}, '{"G351","VAL ERR!"},
        '{"b0","OK"}, '{"B350","OK"}, '{"o15","OK"}, '{"O16","VAL ERR!"}, '{"p0","OK"},
        '{"P15","OK"}, '{"v6","OK"}, '{"v2","VAL ERR!"}, '{"C2","OK"}, '{"C3","VAL ERR!"},
        '{"M255","OK"}, '{"M256","VAL ERR!"}, '{"c1","OK"}, '{"s128","OK"}, '{"s129","VAL ERR!"},
        '{"S129","OK"}, '{"S128","VAL ERR!"}, '{"R1","OK"}, '{"T1","OK"}, '{"T2","VAL ERR!"},
        '{"W","OK"}, '{"K","OK"}, '{"L","OK"}, '{"w","OK"}, '{"x","CMD ERR!"},
        '{"5","CMD ERR!"}, '{"g","VAL ERR!"}};
    always #10 pclk = ~pclk;
    always @(posedge pclk) mem_done <= mem_req && !mem_done;
    always @(posedge pclk) cc1_trig <= ~cc1_trig;
    cscp_parser #(.BAUD_DIV(8)) cscp_parser_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_cmd_in(ser_cmd_in), .ser_reply_out(ser_reply_out),
        .cc1_trig(cc1_trig), .trig_out(trig_out), .mem_req(mem_req), .mem_op(), .mem_wcfg(),
        .mem_rcfg(mem_rcfg), .mem_done(mem_done), .mem_err(mem_err), .cap_white(cap_white),
        .cap_black(cap_black), .exp_mode(exp_mode), .scan_period(scan_period),
        .gain_a_odd(gain_a_odd), .gain_a_even(), .gain_b_odd(), .gain_b_even(),
        .offset_a_odd(), .offset_a_even(), .offset_b_odd(), .offset_b_even(), .video_fmt(),
        .corr_sel(), .corr_target(), .dl_enable(), .dl_min(), .dl_max(), .dir_reverse(),
        .test_pattern());
    cscp_host_model #(.BAUD_DIV(8)) host_i (.clk(pclk), .tx(ser_cmd_in), .rx(ser_reply_out));
    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic run(input string c, input string x);
        host_i.send(c, to);
        check(!to && host_i.rs == x, c);
        if (to) finish_test();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        bit ok;
        ok = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        if (!ok) begin
            check(1'b0, "bus timeout");
            finish_test();
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rows[k]) run(rows[k].c, {">", rows[k].r, "\015>", rows[k].c, "\015\004"});
        check(exp_mode === 2'h3 && gain_a_odd === 9'd350, "rejected value changed");
        run("i12345678", ">CMD OVR ERR!\015>i1234567\015\004");
        mem_err <= 1;
        run("w", ">MEM ERR!\015>w\015\004");
        mem_err <= 0;
        run("I", {">OK\015>", $sformatf("%027h", {2'b00, mem_rcfg}), "\015>I\015\004"});
        check(exp_mode === 2'h2 && scan_period === 20'd4000, "load");
        apb(0, 12'h010, 0);
        check(rd === mem_rcfg[31:0] && e === 1'b0, "cfg0 read");
        apb(0, 12'h020, 0);
        check(e === 1'b1 && rd === 0, "unmapped read");
        apb(1, 12'h000, 0);
        host_i.send("t1", to);
        check(to === 1'b1, "reply while disabled");
        apb(1, 12'h000, 1);
        run("z", ">OK\015>z\015\004");
        check(exp_mode === 2'h0 && gain_a_odd === 9'd0, "defaults");
        finish_test();
    end
endmodule // tb
`default_nettype wire
